/* File: hdl/kd_pkg.sv */
package kd_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Program string layout, shifted in lowest bit first
  localparam int PROG_BITS = 80;
  localparam logic [6:0] PROG_BITS_W = 7'h50;
  localparam int CMD_LSB = 0;
  localparam int CFG_LSB = 8;
  localparam int MFR_LSB = 16;
  localparam logic [7:0] CMD_PROGRAM = 8'hB4;

  // Configuration byte fields, bits 3..7 reserved
  localparam int CFG_LEARN_MODE_BIT = 0;
  localparam int CFG_LEARN_ALG_BIT = 1;
  localparam int CFG_REPEAT_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_USED_MASK = 8'h07;

  // Seed patching
  localparam logic [3:0] NORMAL_HI_NIBBLE = 4'h6;
  localparam logic [3:0] NORMAL_LO_NIBBLE = 4'h2;
  localparam logic [3:0] SEED_TOP_ZERO = 4'h0;
  localparam int SN_LSB = 32;
  localparam int SN_BITS = 28;

  // Acknowledge may not rise earlier than this after activation
  localparam int CLK_HZ = 40000000;
  localparam int ACK_MIN_MS = 30;
  localparam int ACK_MIN_CYC = (ACK_MIN_MS * CLK_HZ) / 1000;

  // Block cipher
  localparam logic [9:0] CIPHER_ROUNDS = 10'h210;
  // Arbitrary values, not taken from any real part
  localparam logic [31:0] NLF_TABLE = 32'h9C6B_2E17;
  localparam logic [63:0] STORAGE_KEY = 64'h5A1F_C3E7_0B92_64D8;

  // System memory map (word addresses)
  localparam logic [1:0] MEM_ADDR_CFG = 2'h0;
  localparam logic [1:0] MEM_ADDR_MFR_HI = 2'h1;
  localparam logic [1:0] MEM_ADDR_MFR_LO = 2'h2;

  // Encoder seed width
  typedef enum logic [1:0] {SEED_W32, SEED_W48, SEED_W60} kd_seed_w_t;
endpackage

/* File: hdl/kd_sysmem.sv */
// Read-protected system memory: no port reaches it from outside the block
module kd_sysmem (
  // Clock
  input wire logic clk,
  input wire logic clk_en,
  // Access
  input wire logic we,
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata_q
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] mem_q [4]; // Storage words
  logic [31:0] rdata_d; // Next read word

  // Read path
  always_comb begin
    rdata_d = mem_q[addr];
  end

  // Registered read
  always_ff @(posedge clk) begin
    if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // One write port per entry
  for (genvar i = 0; i < 4; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (clk_en && we && addr == 2'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end
endmodule // kd_sysmem

/* File: hdl/kd_cipher.sv */
// Iterative 32-bit block cipher, one round per clock
module kd_cipher (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Request
  input wire logic start,
  input wire logic decrypt,
  input wire logic [63:0] key,
  input wire logic [31:0] din,
  // Answer
  output logic busy_q,
  output logic done_q,
  output logic [31:0] dout_q
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] dout_d;
  logic [63:0] key_q, key_d; // Rotating key
  logic [9:0] cnt_q, cnt_d; // Rounds done
  logic dec_q, dec_d;
  logic busy_d, done_d;
  logic fb; // Feedback bit

  // Round logic
  always_comb begin
    dout_d = dout_q;
    key_d = key_q;
    cnt_d = cnt_q;
    dec_d = dec_q;
    busy_d = busy_q;
    done_d = 1'b0;
    fb = 1'b0;
    if (start && !busy_q) begin
      dout_d = din;
      key_d = key;
      dec_d = decrypt;
      cnt_d = '0;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (dec_q) begin
        // Inverse round walks the key backwards
        fb = dout_q[31] ^ dout_q[15] ^ key_q[15] ^ kd_pkg::NLF_TABLE[{dout_q[30],
            dout_q[25], dout_q[19], dout_q[8], dout_q[0]}];
        dout_d = {dout_q[30:0], fb};
        key_d = {key_q[62:0], key_q[63]};
      end else begin
        fb = dout_q[0] ^ dout_q[16] ^ key_q[0] ^ kd_pkg::NLF_TABLE[{dout_q[31],
            dout_q[26], dout_q[20], dout_q[9], dout_q[1]}];
        dout_d = {fb, dout_q[31:1]};
        key_d = {key_q[0], key_q[63:1]};
      end
      cnt_d = cnt_q + 10'h001;
      if (cnt_d == kd_pkg::CIPHER_ROUNDS) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
      key_q <= '0;
      cnt_q <= '0;
      dec_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      dout_q <= dout_d;
      key_q <= key_d;
      cnt_q <= cnt_d;
      dec_q <= dec_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
endmodule // kd_cipher

/* File: hdl/kd_learn_key.sv */
// What this block does
// - Program string is exactly 80 bits
// - Command, configuration, code; each LSB first
// - Code stored encrypted under internal storage key
// - Data line high acknowledges finished write
// - System memory unreadable, written only by program
// - Config bit 0 picks normal or secure learn
// - Config bit 1 picks decryption or XOR in secure learn
// - Config bit 2 repeat reporting; 3-7 reserved
// - Normal seeds: 0x6 and 0x2 over serial
// - Normal key halves decrypt the two seeds
// - Secure seed: low 64 bits, top 4 zero
// - 32-bit seed: serial low 28, then seed
// - 48-bit seed: serial kept unshifted, top 4 zero, plus seed
// - 60-bit seed: upper 32 cleared top, lower 32
// - Secure decrypt: halves decrypt seeds under code
// - Secure XOR: halves XOR code halves
// - Program command byte is B4
module kd_learn_key #(
  parameter int ACK_MIN_CYC = kd_pkg::ACK_MIN_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial link pins
  input wire logic ser_clk,
  input wire logic ser_dat_in,
  output logic ser_dat_out_q,
  output logic ser_dat_oe_q,
  // Learn request
  input wire logic learn_start,
  input wire logic [63:0] code_word,
  input wire kd_pkg::kd_seed_w_t seed_width,
  // Learn answer
  output logic key_valid_q,
  output logic [31:0] key_upper_half_q,
  output logic [31:0] key_lower_half_q,
  // Status
  output logic busy_q,
  output logic programmed_q,
  output logic learn_mode_select_q,
  output logic learn_algorithm_select_q,
  output logic repeat_report_en_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q; // Reset release chain
  logic rst_s_n; // Synchronised reset
  logic [2:0] sclk_q; // Two sync stages plus edge history
  logic [1:0] sdat_q; // Two sync stages
  logic sclk_rise;
  logic sclk_low;

  // Release through two flops, assert at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_q[1];

  // Pin samplers; edges only seen from the second stage on
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sclk_q <= 3'b000;
      sdat_q <= 2'b00;
    end else if (clk_en) begin
      sclk_q <= {sclk_q[1:0], ser_clk};
      sdat_q <= {sdat_q[0], ser_dat_in};
    end
  end
  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign sclk_low = !sclk_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  typedef enum logic [4:0] {
    ST_IDLE, ST_ARM, ST_CIPH, ST_ENC_LO, ST_WR_CFG, ST_WR_HI, ST_WR_LO,
    ST_WAIT_ACK, ST_ACK, ST_L_RD_HI, ST_L_DEC_HI, ST_L_RD_LO, ST_L_DEC_LO,
    ST_L_SEED, ST_L_KEY_LO, ST_L_DONE
  } kd_state_t;

  kd_state_t state_q, state_d; // Current step
  kd_state_t ret_q, ret_d; // Step after cipher run
  logic [79:0] sr_q, sr_d; // Program string shifter
  logic [6:0] bits_q, bits_d; // Bits received
  logic [31:0] tmr_q, tmr_d; // Time since activation
  logic [31:0] enc_hi_q, enc_hi_d; // Encrypted code upper word
  logic [31:0] mfr_hi_q, mfr_hi_d; // Plain code, learn only
  logic [31:0] mfr_lo_q, mfr_lo_d;
  logic [63:0] cw_q, cw_d; // Captured code word
  kd_pkg::kd_seed_w_t sw_q, sw_d;
  logic [31:0] seed_lo_q, seed_lo_d; // Held for second decryption
  logic [7:0] cfg_q, cfg_d; // Live configuration byte
  logic prog_q, prog_d;
  logic dout_d, doe_d, kv_d, busy_d;
  logic [31:0] kh_d, kl_d;
  // Cipher request
  logic c_start;
  logic c_dec;
  logic [63:0] c_key;
  logic [31:0] c_din;
  logic c_busy, c_done;
  logic [31:0] c_dout;
  // System memory port
  logic m_we;
  logic [1:0] m_addr;
  logic [31:0] m_wdata, m_rdata;
  // Seed forming
  logic [63:0] seed60; // Low 64 bits, top nibble cleared
  logic [27:0] sn28; // Serial number field
  logic [31:0] seed_hi_c, seed_lo_c; // Seed words for this learn

  // Seed words for the mode in force
  always_comb begin
    seed60 = {kd_pkg::SEED_TOP_ZERO, cw_q[59:0]};
    sn28 = cw_q[kd_pkg::SN_LSB +: kd_pkg::SN_BITS];
    if (!cfg_q[kd_pkg::CFG_LEARN_MODE_BIT]) begin
      seed_hi_c = {kd_pkg::NORMAL_HI_NIBBLE, sn28};
      seed_lo_c = {kd_pkg::NORMAL_LO_NIBBLE, sn28};
    end else begin
      case (sw_q)
        kd_pkg::SEED_W32: begin
          seed_hi_c = {kd_pkg::SEED_TOP_ZERO, sn28};
          seed_lo_c = seed60[31:0];
        end
        kd_pkg::SEED_W48: begin
          // Serial high half, top nibble zero, over seed bits 47..32
          seed_hi_c = {kd_pkg::SEED_TOP_ZERO, seed60[59:48], seed60[47:32]};
          seed_lo_c = seed60[31:0];
        end
        default: begin
          seed_hi_c = seed60[63:32];
          seed_lo_c = seed60[31:0];
        end
      endcase
    end
  end

  // Next-state logic
  always_comb begin
    state_d = state_q;
    ret_d = ret_q;
    sr_d = sr_q;
    bits_d = bits_q;
    tmr_d = tmr_q;
    enc_hi_d = enc_hi_q;
    mfr_hi_d = mfr_hi_q;
    mfr_lo_d = mfr_lo_q;
    cw_d = cw_q;
    sw_d = sw_q;
    seed_lo_d = seed_lo_q;
    cfg_d = cfg_q;
    prog_d = prog_q;
    dout_d = 1'b0;
    doe_d = 1'b0;
    kv_d = 1'b0;
    kh_d = key_upper_half_q;
    kl_d = key_lower_half_q;
    c_start = 1'b0;
    c_dec = 1'b0;
    c_key = kd_pkg::STORAGE_KEY;
    c_din = '0;
    m_we = 1'b0;
    m_addr = kd_pkg::MEM_ADDR_CFG;
    m_wdata = '0;
    // Activation timer saturates well past the limit
    if (tmr_q != 32'hFFFF_FFFF) begin
      tmr_d = tmr_q + 32'h0000_0001;
    end
    case (state_q)
      ST_IDLE: begin
        if (learn_start && prog_q) begin
          // A learn needs a stored code to work from
          cw_d = code_word;
          sw_d = seed_width;
          state_d = ST_L_RD_HI;
        end else if (sclk_rise) begin
          // Shift right so the first bit ends up at bit 0
          sr_d = {sdat_q[1], sr_q[79:1]};
          bits_d = bits_q + 7'h01;
          if (bits_d == kd_pkg::PROG_BITS_W) begin
            bits_d = '0;
            if (sr_d[kd_pkg::CMD_LSB +: 8] == kd_pkg::CMD_PROGRAM) begin
              state_d = ST_ARM;
            end
          end
        end
      end
      ST_ARM: begin
        // Clock raised after the string activates the write
        if (sclk_rise) begin
          tmr_d = '0;
          c_start = 1'b1;
          c_din = sr_q[kd_pkg::MFR_LSB + 32 +: 32];
          ret_d = ST_ENC_LO;
          state_d = ST_CIPH;
        end
      end
      ST_CIPH: begin
        if (c_done) begin
          state_d = ret_q;
        end
      end
      ST_ENC_LO: begin
        enc_hi_d = c_dout;
        c_start = 1'b1;
        c_din = sr_q[kd_pkg::MFR_LSB +: 32];
        ret_d = ST_WR_CFG;
        state_d = ST_CIPH;
      end
      ST_WR_CFG: begin
        // Only the program sequence writes system memory
        m_we = 1'b1;
        m_addr = kd_pkg::MEM_ADDR_CFG;
        m_wdata = {24'h00_0000, sr_q[kd_pkg::CFG_LSB +: 8]};
        state_d = ST_WR_HI;
      end
      ST_WR_HI: begin
        m_we = 1'b1;
        m_addr = kd_pkg::MEM_ADDR_MFR_HI;
        m_wdata = enc_hi_q;
        state_d = ST_WR_LO;
      end
      ST_WR_LO: begin
        m_we = 1'b1;
        m_addr = kd_pkg::MEM_ADDR_MFR_LO;
        m_wdata = c_dout;
        cfg_d = sr_q[kd_pkg::CFG_LSB +: 8];
        prog_d = 1'b1;
        state_d = ST_WAIT_ACK;
      end
      ST_WAIT_ACK: begin
        // Host reads an early rise as failure, so hold off
        if (tmr_q >= 32'(ACK_MIN_CYC)) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        // Data high until the host lowers the clock
        dout_d = 1'b1;
        doe_d = 1'b1;
        if (sclk_low) begin
          dout_d = 1'b0;
          doe_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_L_RD_HI: begin
        m_addr = kd_pkg::MEM_ADDR_MFR_HI;
        state_d = ST_L_DEC_HI;
      end
      ST_L_DEC_HI: begin
        // Recover plain code from its stored form
        c_start = 1'b1;
        c_dec = 1'b1;
        c_din = m_rdata;
        ret_d = ST_L_RD_LO;
        state_d = ST_CIPH;
      end
      ST_L_RD_LO: begin
        mfr_hi_d = c_dout;
        m_addr = kd_pkg::MEM_ADDR_MFR_LO;
        state_d = ST_L_DEC_LO;
      end
      ST_L_DEC_LO: begin
        c_start = 1'b1;
        c_dec = 1'b1;
        c_din = m_rdata;
        ret_d = ST_L_SEED;
        state_d = ST_CIPH;
      end
      ST_L_SEED: begin
        mfr_lo_d = c_dout;
        seed_lo_d = seed_lo_c;
        if (cfg_q[kd_pkg::CFG_LEARN_MODE_BIT] && cfg_q[kd_pkg::CFG_LEARN_ALG_BIT]) begin
          kh_d = seed_hi_c ^ mfr_hi_q;
          kl_d = seed_lo_c ^ c_dout;
          kv_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          // Normal learn always decrypts, whatever bit 1 says
          c_start = 1'b1;
          c_dec = 1'b1;
          c_key = {mfr_hi_q, c_dout};
          c_din = seed_hi_c;
          ret_d = ST_L_KEY_LO;
          state_d = ST_CIPH;
        end
      end
      ST_L_KEY_LO: begin
        kh_d = c_dout;
        c_start = 1'b1;
        c_dec = 1'b1;
        c_key = {mfr_hi_q, mfr_lo_q};
        c_din = seed_lo_q;
        ret_d = ST_L_DONE;
        state_d = ST_CIPH;
      end
      ST_L_DONE: begin
        kl_d = c_dout;
        kv_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      sr_q <= '0;
      bits_q <= '0;
      tmr_q <= '0;
      enc_hi_q <= '0;
      mfr_hi_q <= '0;
      mfr_lo_q <= '0;
      cw_q <= '0;
      sw_q <= kd_pkg::SEED_W32;
      seed_lo_q <= '0;
      cfg_q <= kd_pkg::CFG_RESET;
      prog_q <= 1'b0;
      ser_dat_out_q <= 1'b0;
      ser_dat_oe_q <= 1'b0;
      key_valid_q <= 1'b0;
      key_upper_half_q <= '0;
      key_lower_half_q <= '0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      ret_q <= ret_d;
      sr_q <= sr_d;
      bits_q <= bits_d;
      tmr_q <= tmr_d;
      enc_hi_q <= enc_hi_d;
      mfr_hi_q <= mfr_hi_d;
      mfr_lo_q <= mfr_lo_d;
      cw_q <= cw_d;
      sw_q <= sw_d;
      seed_lo_q <= seed_lo_d;
      cfg_q <= cfg_d;
      prog_q <= prog_d;
      ser_dat_out_q <= dout_d;
      ser_dat_oe_q <= doe_d;
      key_valid_q <= kv_d;
      key_upper_half_q <= kh_d;
      key_lower_half_q <= kl_d;
      busy_q <= busy_d;
    end
  end

  // Status mirrors; reserved bits never leave the block
  assign programmed_q = prog_q;
  assign learn_mode_select_q = cfg_q[kd_pkg::CFG_LEARN_MODE_BIT];
  assign learn_algorithm_select_q = cfg_q[kd_pkg::CFG_LEARN_ALG_BIT];
  assign repeat_report_en_q = cfg_q[kd_pkg::CFG_REPEAT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Shared cipher and memory
  kd_cipher u_cipher (
    .clk(clk),
    .rst_n(rst_s_n),
    .clk_en(clk_en),
    .start(c_start),
    .decrypt(c_dec),
    .key(c_key),
    .din(c_din),
    .busy_q(c_busy),
    .done_q(c_done),
    .dout_q(c_dout)
  );

  kd_sysmem u_sysmem (
    .clk(clk),
    .clk_en(clk_en),
    .we(m_we && clk_en),
    .addr(m_addr),
    .wdata(m_wdata),
    .rdata_q(m_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  property p_bit_count;
    bits_q < kd_pkg::PROG_BITS_W;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bit count overran");

  property p_arm_cmd;
    (state_q == ST_ARM && $past(state_q) == ST_IDLE) |-> sr_q[7:0] == kd_pkg::CMD_PROGRAM;
  endproperty
  a_arm_cmd: assert property (p_arm_cmd) else $error("armed on wrong command");

  property p_ack_late;
    $rose(ser_dat_oe_q) |-> tmr_q > 32'(ACK_MIN_CYC);
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("ack too early");

  property p_ack_hold;
    (ser_dat_oe_q && sclk_q[1] && clk_en) |=> ser_dat_oe_q && ser_dat_out_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");

  property p_write_only_prog;
    m_we |-> (state_q inside {ST_WR_CFG, ST_WR_HI, ST_WR_LO});
  endproperty
  a_write_only_prog: assert property (p_write_only_prog) else $error("stray write");

  property p_cfg_load;
    (state_q == ST_WR_LO && clk_en) |=> cfg_q == $past(sr_q[15:8]) && programmed_q;
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");

  property p_normal_seed;
    (state_q == ST_L_SEED && !learn_mode_select_q) |->
      seed_hi_c == {4'h6, cw_q[59:32]} && seed_lo_c == {4'h2, cw_q[59:32]};
  endproperty
  a_normal_seed: assert property (p_normal_seed) else $error("bad normal seed");

  property p_secure_top;
    (state_q == ST_L_SEED && learn_mode_select_q) |-> seed_hi_c[31:28] == 4'h0;
  endproperty
  a_secure_top: assert property (p_secure_top) else $error("seed top not zero");

  property p_xor_key;
    (state_q == ST_L_SEED && learn_mode_select_q && learn_algorithm_select_q && clk_en)
      |=> key_valid_q && key_upper_half_q == ($past(seed_hi_c) ^ mfr_hi_q);
  endproperty
  a_xor_key: assert property (p_xor_key) else $error("xor key wrong");

  property p_learn_gated;
    (state_q == ST_IDLE && learn_start && !programmed_q && clk_en) |=> state_q == ST_IDLE
      || state_q == ST_ARM;
  endproperty
  a_learn_gated: assert property (p_learn_gated) else $error("learn before program");

  property p_cipher_free;
    c_start |-> !c_busy;
  endproperty
  a_cipher_free: assert property (p_cipher_free) else $error("cipher start while busy");
endmodule // kd_learn_key

/* File: sim/kd_host_model.sv */
// Host side of the serial link: shifts program strings and waits for the acknowledge
module kd_host_model (
  // Clock used only to count acknowledge delay
  input wire logic clk,
  // Link pins
  output logic ser_clk,
  output logic ser_dat,
  input wire logic dat_wire
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link clock stands low outside strings
  initial begin
    ser_clk = 1'b0;
    ser_dat = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One program string, 200 ns per bit; cyc returns clocks until data line high
  task automatic send(input logic [7:0] cmd, input logic [7:0] cfg, input logic [63:0] code,
      input bit act, input int limit, output int cyc);
    logic [79:0] s;
    s = {code, cfg, cmd};
    cyc = 0;
    for (int i = 0; i < 80; i++) begin
      // Data moves mid-low so it is stable around the rise
      #50 ser_dat = s[i];
      #50 ser_clk = 1'b1;
      #100 ser_clk = 1'b0;
    end
    // Released line: pull-down level, so only the device can raise it
    #50 ser_dat = 1'b0;
    if (act) begin
      #50 ser_clk = 1'b1;
      // Clock held high until the line rises or limit clocks pass; an early rise is a failure
      while (dat_wire !== 1'b1 && cyc < limit) begin
        @(posedge clk);
        // Look once the edge's register updates have settled
        #1 cyc++;
      end
      #100 ser_clk = 1'b0;
    end
    #200;
  endtask
endmodule // kd_host_model

/* File: sim/kd_learn_key_bench.sv */
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, (e), (g)); end end

// Program the block over the link, then derive keys in every mode
module kd_learn_key_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Short acknowledge floor keeps the run brief
  localparam int ACKC = 2000;
  localparam int CEIL = 60000;
  localparam logic [63:0] CODE = 64'h0123_4567_89AB_CDEF;
  // Serial in 59:32, seed below, top nibble set to prove it is dropped
  localparam logic [63:0] CW = 64'hF9AB_CDE1_2345_6789;
  localparam logic [63:0] CWA = 64'hA123_4567_6123_4567;

  logic clk, rst_n, clk_en, ser_clk, host_dat, dat_wire, dout, oe;
  logic learn_start, key_valid_q, busy_q, programmed_q, ok, armed;
  logic learn_mode_select_q, learn_algorithm_select_q, repeat_report_en_q;
  logic [63:0] code_word;
  logic [31:0] key_upper_half_q, key_lower_half_q, hi, lo, ha, la;
  kd_pkg::kd_seed_w_t seed_width;
  int failures, num_checks, cycles;

  // Wire level: device wins while it drives
  assign dat_wire = oe ? dout : host_dat;

  kd_learn_key #(.ACK_MIN_CYC(ACKC)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .ser_clk(ser_clk), .ser_dat_in(dat_wire), .ser_dat_out_q(dout), .ser_dat_oe_q(oe),
    .learn_start(learn_start), .code_word(code_word), .seed_width(seed_width),
    .key_valid_q(key_valid_q), .key_upper_half_q(key_upper_half_q),
    .key_lower_half_q(key_lower_half_q), .busy_q(busy_q), .programmed_q(programmed_q),
    .learn_mode_select_q(learn_mode_select_q),
    .learn_algorithm_select_q(learn_algorithm_select_q),
    .repeat_report_en_q(repeat_report_en_q)
  );

  kd_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_dat(host_dat), .dat_wire(dat_wire));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == CEIL) begin
      failures++;
      finish_test();
    end
  end

  // Program string, then acknowledge and configuration checks
  task automatic prog(input logic [7:0] cmd, input logic [7:0] cfg, input bit act);
    int cyc;
    host.send(cmd, cfg, CODE, act, ACKC + 3000, cyc);
    if (act) begin
      armed = 1'b1;
      `CHK("ack_seen", 1'b1, cyc < ACKC + 3000)
      `CHK("ack_not_early", 1'b1, cyc > ACKC)
    end
    repeat (10) @(posedge clk);
    #1 `CHK("ack_released", 1'b0, oe)
    `CHK("programmed", act, programmed_q)
    `CHK("learn_mode", act & cfg[0], learn_mode_select_q)
    `CHK("learn_alg", act & cfg[1], learn_algorithm_select_q)
    `CHK("repeat_en", act & cfg[2], repeat_report_en_q)
    $display("test program %h %h done", cmd, cfg);
  endtask

  // One learn request; waits bounded for the valid pulse
  task automatic learn(input logic [63:0] cw, input kd_pkg::kd_seed_w_t w);
    ok = 1'b0;
    @(posedge clk);
    #2 learn_start = 1'b1;
    code_word = cw;
    seed_width = w;
    @(posedge clk);
    #2 learn_start = 1'b0;
    `CHK("busy", armed, busy_q)
    for (int i = 0; i < 3000 && !ok; i++) begin
      @(posedge clk);
      #1 if (key_valid_q === 1'b1) begin
        ok = 1'b1;
        hi = key_upper_half_q;
        lo = key_lower_half_q;
      end
      // Ten frozen cycles mid-run must leave the key unchanged
      #1 clk_en = ok || i < 100 || i >= 110;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    learn_start = 1'b0;
    code_word = '0;
    seed_width = kd_pkg::SEED_W32;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    armed = 1'b0;
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 `CHK("rst_oe", 1'b0, oe)
    learn(CW, kd_pkg::SEED_W60);
    `CHK("unprogrammed_learn", 1'b0, ok)
    $display("test refuse done");
    // Wrong command byte is dropped, nothing stored
    prog(8'hB5, 8'h07, 1'b0);
    // Secure XOR, reserved bits set, repeat off
    prog(kd_pkg::CMD_PROGRAM, 8'hFB, 1'b1);
    for (int i = 0; i < 3; i++) begin
      learn(CW, kd_pkg::kd_seed_w_t'(i));
      `CHK("xor_valid", 1'b1, ok)
      `CHK("xor_hi", {4'h0, CW[59:32]} ^ CODE[63:32], hi)
      `CHK("xor_lo", CW[31:0] ^ CODE[31:0], lo)
    end
    $display("test xor done");
    // Secure decryption: widths and top nibble must not change the key
    prog(kd_pkg::CMD_PROGRAM, 8'h01, 1'b1);
    learn(CWA, kd_pkg::SEED_W60);
    `CHK("dec_valid", 1'b1, ok)
    ha = hi;
    la = lo;
    learn(CWA, kd_pkg::SEED_W32);
    `CHK("dec_w32_hi", ha, hi)
    `CHK("dec_w32_lo", la, lo)
    learn({4'h3, CWA[59:0]}, kd_pkg::SEED_W60);
    `CHK("dec_top_hi", ha, hi)
    `CHK("dec_top_lo", la, lo)
    $display("test secure decrypt done");
    // Normal learn: high seed 0x6 over serial equals decrypted low word above
    prog(kd_pkg::CMD_PROGRAM, 8'h06, 1'b1);
    learn({4'h5, CWA[27:0], 32'hDEAD_BEEF}, kd_pkg::SEED_W48);
    `CHK("normal_valid", 1'b1, ok)
    `CHK("normal_hi", la, hi)
    $display("test normal done");
    finish_test();
  end
endmodule // kd_learn_key_bench
